// ### lpmcr_regs.sv
`timescale 1ns/10ps
module lpmcr_regs #(
  parameter logic [5:0] CAP_SUPPORT = 6'h3f,
  parameter logic [7:0] NEXT_PTR    = 8'h00,
  parameter bit         IS_CHIPSET  = 1'b1,
  parameter int         ADDR_W      = 12,
  parameter int         SMP_W       = 32
)(
  // Clock and resets.
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic                        warmRstN,
  // APB slave.
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Settings for the link management controller.
  output logic                             discLaneRefreshEnable,
  output logic                             inactiveLaneRefreshEnable,
  output logic                             dynFrequencyEnable,
  output logic                             dynWidthEnable,
  output logic                             dynDisconnectEnable,
  output logic                             dynConfigEnable,
  output logic      [lpmcr_pkg::FREQ_W-1:0] allowedFrequencyMask,
  output logic      [lpmcr_pkg::REF_W-1:0]  refreshInterval,
  output logic      [lpmcr_pkg::REF_W-1:0]  refreshLength,
  // Upstream packet path.
  input  wire logic                        upInValid,
  input  wire logic [SMP_W-1:0]            upInData,
  output logic                             upInReady,
  output logic                             upOutValid,
  output logic      [SMP_W-1:0]            upOutData,
  input  wire logic                        upOutReady,
  // Downstream packet path.
  input  wire logic                        dnInValid,
  input  wire logic [SMP_W-1:0]            dnInData,
  output logic                             dnInReady,
  output logic                             dnOutValid,
  output logic      [SMP_W-1:0]            dnOutData,
  input  wire logic                        dnOutReady
);
  import lpmcr_pkg::*;

  // ---------------------------------------------------------------
  // Implemented registers and writable enables
  // ---------------------------------------------------------------
  localparam logic       FEAT_IMPL = |CAP_SUPPORT;
  localparam logic       FREQ_IMPL = IS_CHIPSET && CAP_SUPPORT[F_FREQ];
  localparam logic       REF_IMPL  = IS_CHIPSET && CAP_SUPPORT[F_DISC_REFR];
  localparam logic [5:0] CHIP_MASK = IS_CHIPSET ? 6'h3f : 6'h1f;
  localparam logic [5:0] EN_WR_MSK = CAP_SUPPORT & CHIP_MASK;

  // ---------------------------------------------------------------
  // Warm reset synchroniser
  // ---------------------------------------------------------------
  // Warm reset comes from a pin, so it is synchronised and acts as a
  // synchronous clear; cold reset alone is the asynchronous one.
  logic warmSync1_r;
  logic warmSync2_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warmSync1_r <= 1'b0;
      warmSync2_r <= 1'b0;
    end else begin
      warmSync1_r <= warmRstN;
      warmSync2_r <= warmSync1_r;
    end
  end

  wire logic warmRst = ~warmSync2_r;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire logic setupPh = psel & ~penable;
  wire logic accessPh = psel & penable;
  wire logic hdrHit = (paddr == HDR_OFS[ADDR_W-1:0]);
  wire logic dataHit = (paddr == DATA_OFS[ADDR_W-1:0]);
  wire logic wrEn = accessPh & pwrite;
  wire logic hdrWr = wrEn & hdrHit;
  wire logic dataWr = wrEn & dataHit;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [IDX_W-1:0]  idx_r;
  logic [IDX_W-1:0]  idx_nxt;
  logic [FEAT_N-1:0] en_r;
  logic [FEAT_N-1:0] en_nxt;
  logic [FREQ_W-1:0] freq_r;
  logic [FREQ_W-1:0] freq_nxt;
  logic [REF_W-1:0]  refInt_r;
  logic [REF_W-1:0]  refInt_nxt;
  logic [REF_W-1:0]  refLen_r;
  logic [REF_W-1:0]  refLen_nxt;
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;

  // Only bits 19:16 of the header are writable.
  assign idx_nxt = hdrWr ? pwdata[HDR_IDX_LSB +: IDX_W] : idx_r;

  wire logic featWr = dataWr & (idx_r == IDX_FEATURE) & FEAT_IMPL;
  wire logic freqWr = dataWr & (idx_r == IDX_FREQ) & FREQ_IMPL;
  wire logic refWr = dataWr & (idx_r == IDX_REFRESH) & REF_IMPL;

  // Enables without capability keep their reset value of zero.
  wire logic [FEAT_N-1:0] enWr =
    featWr ? (pwdata[EN_LSB +: FEAT_N] & EN_WR_MSK) : en_r;
  // Warm reset clears bits 21, 17 and 16; bits 20..18 survive it.
  assign en_nxt = enWr & (warmRst ? ~WARM_EN_MASK : 6'h3f);

  assign freq_nxt = warmRst ? FREQ_RST :
                    freqWr  ? pwdata[FREQ_W-1:0] : freq_r;
  assign refInt_nxt = warmRst ? REF_RST :
                      refWr   ? pwdata[REF_INT_LSB +: REF_W] : refInt_r;
  assign refLen_nxt = warmRst ? REF_RST :
                      refWr   ? pwdata[REF_LEN_LSB +: REF_W] : refLen_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_r    <= IDX_RST;
      en_r     <= EN_RST;
      freq_r   <= FREQ_RST;
      refInt_r <= REF_RST;
      refLen_r <= REF_RST;
    end else begin
      idx_r    <= idx_nxt;
      en_r     <= en_nxt;
      freq_r   <= freq_nxt;
      refInt_r <= refInt_nxt;
      refLen_r <= refLen_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire logic [31:0] hdrRd = {CAP_TYPE, 7'h00, idx_r, NEXT_PTR, CAP_ID};
  wire logic [31:0] featRd =
    FEAT_IMPL ? {10'h000, en_r, 10'h000, CAP_SUPPORT} : 32'h0000_0000;
  wire logic [31:0] freqRd =
    FREQ_IMPL ? {16'h0000, freq_r} : 32'h0000_0000;
  wire logic [31:0] refRd =
    REF_IMPL ? {20'h0_0000, refInt_r, refLen_r} : 32'h0000_0000;
  wire logic [31:0] dataRd =
    (idx_r == IDX_FEATURE) ? featRd :
    (idx_r == IDX_FREQ)    ? freqRd :
    (idx_r == IDX_REFRESH) ? refRd  : 32'h0000_0000;
  wire logic [31:0] rdMux =
    hdrHit  ? hdrRd  :
    dataHit ? dataRd : 32'h0000_0000;

  // Read data is caught in the setup cycle so it leaves a flop and
  // stands stable for the whole access cycle.
  assign prdata_nxt = (setupPh & ~pwrite) ? rdMux : prdata_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~(hdrHit | dataHit);

  // ---------------------------------------------------------------
  // Controller outputs
  // ---------------------------------------------------------------
  // The controller must only sequence features whose enable is set.
  assign discLaneRefreshEnable     = en_r[F_DISC_REFR];
  assign inactiveLaneRefreshEnable = en_r[F_INACTIVE];
  assign dynFrequencyEnable        = en_r[F_FREQ];
  assign dynWidthEnable            = en_r[F_WIDTH];
  assign dynDisconnectEnable       = en_r[F_DISCONNECT];
  assign dynConfigEnable           = en_r[F_CONFIG];
  assign allowedFrequencyMask      = freq_r;
  assign refreshInterval           = refInt_r;
  assign refreshLength             = refLen_r;

  // ---------------------------------------------------------------
  // Packet forwarding in both directions
  // ---------------------------------------------------------------
  lpmcr_smp_if #(.W(SMP_W)) upIn ();
  lpmcr_smp_if #(.W(SMP_W)) upOut ();
  lpmcr_smp_if #(.W(SMP_W)) dnIn ();
  lpmcr_smp_if #(.W(SMP_W)) dnOut ();

  assign upIn.valid  = upInValid;
  assign upIn.data   = upInData;
  assign upInReady   = upIn.ready;
  assign upOutValid  = upOut.valid;
  assign upOutData   = upOut.data;
  assign upOut.ready = upOutReady;
  assign dnIn.valid  = dnInValid;
  assign dnIn.data   = dnInData;
  assign dnInReady   = dnIn.ready;
  assign dnOutValid  = dnOut.valid;
  assign dnOutData   = dnOut.data;
  assign dnOut.ready = dnOutReady;

  // Forwarding works whatever the capability straps say.
  lpmcr_fwd_stage #(.W(SMP_W)) upStage (
    .clk  (clk),
    .nrst (nrst),
    .inp  (upIn),
    .outp (upOut)
  );

  lpmcr_fwd_stage #(.W(SMP_W)) dnStage (
    .clk  (clk),
    .nrst (nrst),
    .inp  (dnIn),
    .outp (dnOut)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  hdr_ident_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (setupPh && !pwrite && hdrHit) |=> (prdata[7:0] == 8'h08))
    else $error("header identifier byte wrong");

  hdr_next_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (setupPh && !pwrite && hdrHit) |=> (prdata[15:8] == NEXT_PTR))
    else $error("header next pointer wrong");

  hdr_index_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (accessPh && pwrite && hdrHit) |=> (idx_r == $past(pwdata[19:16])))
    else $error("index not taken from header write");

  hdr_type_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (setupPh && !pwrite && hdrHit) |=> (prdata[31:20] == 12'he00))
    else $error("header type or reserved bits wrong");

  cap_read_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (setupPh && !pwrite && dataHit && idx_r == 4'h0 && FEAT_IMPL)
      |=> (prdata[5:0] == CAP_SUPPORT && prdata[15:6] == 10'h000))
    else $error("capability flags read wrong");

  no_cap_en_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (en_r & ~CAP_SUPPORT) == 6'h00)
    else $error("enable set without capability");

  warm_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $fell(warmSync2_r) |=> (!dynDisconnectEnable && !dynConfigEnable
      && !discLaneRefreshEnable && refreshLength == 6'h00)[*2])
    else $error("warm reset did not clear its fields");

  cold_keep_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (warmRst && !(accessPh && pwrite))
      |=> $stable(en_r[4:2]))
    else $error("cold-only enable changed by warm reset");

  freq_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (freqWr && !warmRst) |=> (allowedFrequencyMask == $past(pwdata[15:0])))
    else $error("frequency mask not written");

  refr_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (refWr && !warmRst) |=> (refreshInterval == $past(pwdata[11:6])
      && refreshLength == $past(pwdata[5:0])))
    else $error("refresh fields not written");

  unimpl_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (setupPh && !pwrite && dataHit && idx_r > 4'h2) |=> (prdata == 32'h0))
    else $error("unimplemented index read nonzero");

  up_forward_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (upInValid && upInReady) |=> (upOutValid && upOutData == $past(upInData)))
    else $error("upstream packet not forwarded");

  dn_forward_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (dnInValid && dnInReady) |=> (dnOutValid && dnOutData == $past(dnInData)))
    else $error("downstream packet not forwarded");

  fwd_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (upOutValid && !upOutReady) |=> (upOutValid && $stable(upOutData)))
    else $error("upstream packet dropped while stalled");

  dn_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (dnOutValid && !dnOutReady) |=> (dnOutValid && $stable(dnOutData)))
    else $error("downstream packet dropped while stalled");

  en_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (featWr && !warmRst)
      |=> (en_r == ($past(pwdata[21:16]) & EN_WR_MSK)))
    else $error("feature enables not written");

  idx_keep_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (warmRst && !hdrWr) |=> $stable(idx_r))
    else $error("index changed by warm reset");

  freq_read_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (setupPh && !pwrite && dataHit && idx_r == IDX_FREQ && FREQ_IMPL)
      |=> (prdata == {16'h0000, $past(freq_r)}))
    else $error("frequency mask read wrong");

endmodule

// ### lpmcr_pkg.sv
package lpmcr_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ---------------------------------------------------------------
  localparam logic [31:0] HDR_OFS  = 32'h0000_0000;
  localparam logic [31:0] DATA_OFS = 32'h0000_0004;

  // ---------------------------------------------------------------
  // Capability header layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CAP_ID       = 8'h08;
  localparam logic [4:0] CAP_TYPE     = 5'h1c;
  localparam int         HDR_PTR_LSB  = 8;
  localparam int         HDR_IDX_LSB  = 16;
  localparam int         HDR_TYPE_LSB = 27;
  localparam int         IDX_W        = 4;
  localparam logic [3:0] IDX_RST      = 4'h0;

  // ---------------------------------------------------------------
  // Indexed register selectors
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_FEATURE = 4'h0;
  localparam logic [3:0] IDX_FREQ    = 4'h1;
  localparam logic [3:0] IDX_REFRESH = 4'h2;

  // ---------------------------------------------------------------
  // Feature config: feature k has capability bit k, enable bit 16+k
  // ---------------------------------------------------------------
  localparam int         FEAT_N        = 6;
  localparam int         CAP_LSB       = 0;
  localparam int         EN_LSB        = 16;
  localparam int         F_CONFIG      = 0;
  localparam int         F_DISCONNECT  = 1;
  localparam int         F_WIDTH       = 2;
  localparam int         F_FREQ        = 3;
  localparam int         F_INACTIVE    = 4;
  localparam int         F_DISC_REFR   = 5;
  localparam logic [5:0] WARM_EN_MASK  = 6'h23;
  localparam logic [5:0] EN_RST        = 6'h00;

  // ---------------------------------------------------------------
  // Frequency and refresh config
  // ---------------------------------------------------------------
  localparam int          FREQ_W       = 16;
  localparam logic [15:0] FREQ_RST     = 16'h0000;
  localparam int          REF_W        = 6;
  localparam int          REF_LEN_LSB  = 0;
  localparam int          REF_INT_LSB  = 6;
  localparam logic [5:0]  REF_RST      = 6'h00;

endpackage

// ### lpmcr_smp_if.sv
`timescale 1ns/10ps
interface lpmcr_smp_if #(
  parameter int W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### lpmcr_fwd_stage.sv
`timescale 1ns/10ps
module lpmcr_fwd_stage #(
  parameter int W = 32
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Packet in and out.
  lpmcr_smp_if.snk inp,
  lpmcr_smp_if.src outp
);

  logic         full_r;
  logic [W-1:0] data_r;

  // One slot: it takes a new packet whenever the slot drains.
  assign inp.ready  = ~full_r | outp.ready;
  assign outp.valid = full_r;
  assign outp.data  = data_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      full_r <= 1'b0;
      data_r <= '0;
    end else if (inp.ready) begin
      full_r <= inp.valid;
      data_r <= inp.valid ? inp.data : data_r;
    end
  end

endmodule

// ### link_power_mgmt_capability_regs_bench.sv
`timescale 1ns/10ps
module link_power_mgmt_capability_regs_bench;
  import lpmcr_pkg::*;
  logic        clk, nrst, warmRstN, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, upInData, upOutData, dnInData, dnOutData, rdq;
  logic        upInValid, upInReady, upOutValid, upOutReady;
  logic        dnInValid, dnInReady, dnOutValid, dnOutReady, errq;
  logic [15:0] freqMask;
  logic [5:0]  refInt, refLen, enVec;
  logic        enD, enI, enF, enW, enX, enC;
  int          n_errors, check_count;
  assign enVec = {enD, enI, enF, enW, enX, enC};

  lpmcr_regs uut (.clk(clk), .nrst(nrst), .warmRstN(warmRstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .discLaneRefreshEnable(enD), .inactiveLaneRefreshEnable(enI),
    .dynFrequencyEnable(enF), .dynWidthEnable(enW), .dynDisconnectEnable(enX),
    .dynConfigEnable(enC), .allowedFrequencyMask(freqMask), .refreshInterval(refInt),
    .refreshLength(refLen), .upInValid(upInValid), .upInData(upInData), .upInReady(upInReady),
    .upOutValid(upOutValid), .upOutData(upOutData), .upOutReady(upOutReady),
    .dnInValid(dnInValid), .dnInData(dnInData), .dnInReady(dnInReady),
    .dnOutValid(dnOutValid), .dnOutData(dnOutData), .dnOutReady(dnOutReady));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    if (pready !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: no pready on register access", $time);
    end
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdq, exp, msg);
  endtask

  task automatic sel(input logic [3:0] idx);
    apb(1'b1, HDR_OFS[11:0], {12'h000, idx, 16'h0000});
  endtask

  function automatic logic [31:0] hdr(input logic [3:0] idx);
    return {CAP_TYPE, 7'h00, idx, 8'h00, CAP_ID};
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_header;
    rd(HDR_OFS[11:0], hdr(4'h0), "header after reset");
    apb(1'b1, HDR_OFS[11:0], 32'hffff_ffff);
    rd(HDR_OFS[11:0], hdr(4'hf), "header only index writable");
    apb(1'b1, DATA_OFS[11:0], 32'hffff_ffff);
    rd(DATA_OFS[11:0], 32'h0000_0000, "unimplemented index");
  endtask

  task automatic t_feature;
    sel(IDX_FEATURE);
    rd(DATA_OFS[11:0], 32'h0000_003f, "feature config reset");
    apb(1'b1, DATA_OFS[11:0], 32'hffff_ffc0);
    rd(DATA_OFS[11:0], 32'h003f_003f, "feature config all set");
    chk({26'h0, enVec}, 32'h0000_003f, "enable outputs set");
    apb(1'b1, DATA_OFS[11:0], 32'h0015_0000);
    rd(DATA_OFS[11:0], 32'h0015_003f, "feature config pattern");
    chk({26'h0, enVec}, 32'h0000_0015, "enable outputs pattern");
  endtask

  task automatic t_freq_refresh;
    sel(IDX_FREQ);
    rd(DATA_OFS[11:0], 32'h0000_0000, "freq reset");
    apb(1'b1, DATA_OFS[11:0], 32'hffff_a5c3);
    rd(DATA_OFS[11:0], 32'h0000_a5c3, "freq mask");
    chk({16'h0, freqMask}, 32'h0000_a5c3, "freq mask output");
    sel(IDX_REFRESH);
    apb(1'b1, DATA_OFS[11:0], 32'hffff_fabc);
    rd(DATA_OFS[11:0], 32'h0000_0abc, "refresh config");
    chk({20'h0, refInt, refLen}, 32'h0000_0abc, "refresh outputs");
  endtask

  task automatic t_warm;
    sel(IDX_FEATURE);
    apb(1'b1, DATA_OFS[11:0], 32'h003f_0000);
    sel(IDX_REFRESH);
    @(posedge clk);
    warmRstN <= 1'b0;
    repeat (6) @(posedge clk);
    warmRstN <= 1'b1;
    repeat (4) @(posedge clk);
    rd(HDR_OFS[11:0], hdr(IDX_REFRESH), "index kept over warm reset");
    rd(DATA_OFS[11:0], 32'h0000_0000, "refresh cleared by warm reset");
    sel(IDX_FREQ);
    rd(DATA_OFS[11:0], 32'h0000_0000, "freq cleared by warm reset");
    sel(IDX_FEATURE);
    rd(DATA_OFS[11:0], 32'h001c_003f, "cold enables kept");
    chk({26'h0, enVec}, 32'h0000_001c, "enable outputs after warm");
  endtask

  task automatic t_unmapped;
    rd(12'h008, 32'h0000_0000, "unmapped read");
    chk({31'h0, errq}, 32'h0000_0001, "unmapped error flag");
    apb(1'b1, 12'h008, 32'hffff_ffff);
    rd(HDR_OFS[11:0], hdr(IDX_FEATURE), "header untouched");
  endtask

  // The far side stalls for a few cycles, so the word must stand until it is taken.
  task automatic t_fwd(input bit dn, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    if (dn) begin dnInValid <= 1'b1; dnInData <= d; dnOutReady <= 1'b0; end
    else begin upInValid <= 1'b1; upInData <= d; upOutReady <= 1'b0; end
    @(posedge clk);
    while ((dn ? dnInReady : upInReady) !== 1'b1 && n < 50) begin n++; @(posedge clk); end
    dnInValid <= 1'b0; upInValid <= 1'b0; dnInData <= ~d; upInData <= ~d;
    repeat (4) @(posedge clk);
    chk({31'h0, dn ? dnOutValid : upOutValid}, 32'h0000_0001, "forward valid");
    chk(dn ? dnOutData : upOutData, d, "forward data");
    chk({31'h0, dn ? dnInReady : upInReady}, 32'h0000_0000, "forward stall refuses");
    dnOutReady <= 1'b1; upOutReady <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, dn ? dnOutValid : upOutValid}, 32'h0000_0000, "forward drained");
  endtask

  // ---------------------------------------------------------------
  // Closing, clock, reset and watchdog
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100us;
    n_errors++;
    finish_test();
  end

  initial begin
    n_errors = 0; check_count = 0; nrst = 1'b0; warmRstN = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    upInValid = 1'b0; upInData = '0; upOutReady = 1'b1;
    dnInValid = 1'b0; dnInData = '0; dnOutReady = 1'b1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1; warmRstN <= 1'b1;
    repeat (3) @(posedge clk);
    t_header();
    t_feature();
    t_freq_refresh();
    t_warm();
    t_unmapped();
    t_fwd(1'b0, 32'h5a3c_0f81);
    t_fwd(1'b1, 32'hc3a5_7e10);
    finish_test();
  end
endmodule
